// [core/ssr_pkg.sv]
// shared constants and types of the setting store and service request block
// assumes one 200 MHz clock and a command decoder that supplies decoded operations
package ssr_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // locations
    localparam int         NUM_LOCS      = 10;
    localparam logic [3:0] POWER_ON_LOC  = 4'h0;
    localparam logic [3:0] NV_LAST_LOC   = 4'h4;
    localparam logic [3:0] FIRST_VOL_LOC = 4'h5;
    localparam logic [3:0] LAST_LOC      = 4'h9;

    ////////////////////////////////////////////////////////////////////////////////
    // status byte layout
    localparam int         OPER_BIT   = 7;
    localparam int         MSS_BIT    = 6;
    localparam int         ESB_BIT    = 5;
    localparam int         MAV_BIT    = 4;
    localparam int         QUES_BIT   = 3;
    localparam logic [7:0] SRE_RESET  = 8'h00;
    localparam logic [7:0] STB_UNUSED = 8'h07;

    ////////////////////////////////////////////////////////////////////////////////
    // factory values
    localparam logic [15:0] CURRENT_DEFAULT    = 16'h0000;
    localparam logic [15:0] VOLTAGE_DEFAULT    = 16'h0000;
    localparam logic [15:0] TRIG_DELAY_DEFAULT = 16'h0000;
    localparam logic [15:0] LIST_COUNT_DEFAULT = 16'h0001;
    localparam logic [15:0] PROT_DELAY_DEFAULT = 16'h0001;
    localparam logic [15:0] OVP_MAX            = 16'hFFFF;
    localparam logic [3:0]  FAULT_LINK_DEFAULT = 4'h3;

    ////////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {SSR_SRC_BUS, SSR_SRC_IMMEDIATE, SSR_SRC_EXTERNAL,
                              SSR_SRC_LINK} ssr_src_e;

    typedef enum logic [3:0] {SSR_CMD_SET, SSR_CMD_CAL, SSR_CMD_SAVE, SSR_CMD_RECALL,
                              SSR_CMD_RESET, SSR_CMD_SRE_WR, SSR_CMD_CLS,
                              SSR_CMD_STB_Q, SSR_CMD_SRE_Q} ssr_cmd_e;

    typedef struct packed {
        logic        autocal;
        logic [15:0] current;
        logic        curr_list_mode;
        logic        curr_prot;
        logic        display_on;
        logic        init_cont;
        logic [15:0] list_count;
        logic        list_step_once;
        logic        output_on;
        logic        fault_indicator_output;
        logic [3:0]  fault_link;
        logic [15:0] protection_delay;
        logic        relay_on;
        logic        relay_polarity;
        logic        trigger_line_on;
        logic        trigger_line_link;
        ssr_src_e    trigger_line_source;
        logic [15:0] trig_delay;
        logic        trig_link;
        ssr_src_e    trig_source;
        logic [15:0] voltage;
        logic        volt_list_mode;
        logic [15:0] overvoltage_limit;
    } ssr_settings_s;

    localparam ssr_settings_s FACTORY_SETTINGS = '{
        autocal: 1'b0, current: CURRENT_DEFAULT, curr_list_mode: 1'b0, curr_prot: 1'b0,
        display_on: 1'b1, init_cont: 1'b0, list_count: LIST_COUNT_DEFAULT,
        list_step_once: 1'b0, output_on: 1'b0, fault_indicator_output: 1'b0,
        fault_link: FAULT_LINK_DEFAULT, protection_delay: PROT_DELAY_DEFAULT,
        relay_on: 1'b0, relay_polarity: 1'b0, trigger_line_on: 1'b0,
        trigger_line_link: 1'b0, trigger_line_source: SSR_SRC_BUS,
        trig_delay: TRIG_DELAY_DEFAULT, trig_link: 1'b0, trig_source: SSR_SRC_BUS,
        voltage: VOLTAGE_DEFAULT, volt_list_mode: 1'b0, overvoltage_limit: OVP_MAX};

    typedef struct packed {
        ssr_settings_s [NUM_LOCS-1:0] slot;
        logic [7:0]                   sre_nv;
    } ssr_store_s;

endpackage

// [core/ssr_slot_store.sv]
// ten setting locations plus the retained service request enable copy
// assumes it is never reset: locations 0..4 survive a power-on reset of the core, while 5..9 take a copy of location 0
`timescale 1ns/10ps
module ssr_slot_store (
    // clock
    input  wire logic                  core_clk,
    // save port
    input  wire logic                  wr_en,
    input  wire logic [3:0]            wr_idx,
    input  wire ssr_pkg::ssr_settings_s wr_data,
    input  wire logic                  copy_base,
    // recall port
    input  wire logic [3:0]            rd_idx,
    output      ssr_pkg::ssr_settings_s rd_data,
    // retained enable copy
    input  wire logic                  sre_nv_wr,
    input  wire logic [7:0]            sre_nv_data,
    output      logic [7:0]            sre_nv_q
);
    ssr_pkg::ssr_store_s st_reg;
    ssr_pkg::ssr_store_s st_next;

    always_comb begin
        st_next = st_reg;
        if (copy_base) begin
            for (int i = int'(ssr_pkg::FIRST_VOL_LOC); i < ssr_pkg::NUM_LOCS; i++) begin
                st_next.slot[i] = st_reg.slot[ssr_pkg::POWER_ON_LOC];
            end
        end
        if (wr_en && wr_idx <= ssr_pkg::LAST_LOC) begin
            st_next.slot[wr_idx] = wr_data;
        end
        if (sre_nv_wr) begin
            st_next.sre_nv = sre_nv_data;
        end
    end

    // no reset: locations 0..4 and the enable copy model retained storage
    always_ff @(posedge core_clk) begin
        st_reg <= st_next;
    end

    assign rd_data  = (rd_idx <= ssr_pkg::LAST_LOC) ? st_reg.slot[rd_idx]
                                                     : ssr_pkg::FACTORY_SETTINGS;
    assign sre_nv_q = st_reg.sre_nv;
endmodule // ssr_slot_store

// [core/ssr_stb_compose.sv]
// builds the status byte from the summaries and the enable mask
// assumes summary inputs are levels owned by the event registers outside
`timescale 1ns/10ps
module ssr_stb_compose (
    // summaries
    input  wire logic       oper_summary,
    input  wire logic       esb_summary,
    input  wire logic       mav,
    input  wire logic       ques_summary,
    // mask
    input  wire logic [7:0] sre,
    // result
    output      logic [7:0] stb_value,
    output      logic       mss
);
    logic [7:0] raw;

    always_comb begin
        raw                    = 8'h00;
        raw[ssr_pkg::OPER_BIT] = oper_summary;
        raw[ssr_pkg::ESB_BIT]  = esb_summary;
        raw[ssr_pkg::MAV_BIT]  = mav;
        raw[ssr_pkg::QUES_BIT] = ques_summary;
        mss                    = |(raw & sre);
        stb_value              = raw;
        stb_value[ssr_pkg::MSS_BIT] = mss;
    end
endmodule // ssr_stb_compose

// [core/ssr_state_store.sv]
// live setting state, save/recall/reset sequencing, status byte and service request
// assumes decoded commands from the interface logic and serial polls as one-cycle pulses
//
// Behaviour
// - recall of location 0..9 restores every saved setting into the live state
// - an abort pulse precedes the overwrite of settings by a recall
// - every recall forces calibration enable off
// - at power-up the strap selects an automatic recall of location 0
// - at every power-up location 0 is copied into locations 5..9
// - save writes live settings to the location; 0..4 retained, 5..9 volatile
// - saved and recalled state hold the same full set of settings
// - reset command aborts triggers and loads factory setting values
// - enable register takes 0..255; enabled status bits OR into bit 6
// - with enable register zero no service request is ever raised
// - status byte query leaves status contents unchanged
// - message-available bit clears at power-on and on clear-status
// - serial poll returns request flag in bit 6 and clears only that flag
// - status bits: 7 oper, 6 master, 5 event, 4 message, 3 quest; 2..0 zero
// - with power-on clear option 0, enable writes also go to retained storage
// - power-on clear option nonzero clears enable, zero restores last value
`timescale 1ns/10ps
module ssr_state_store (
    // clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   sys_rst,
    // command request
    input  wire logic                   cmd_valid,
    input  wire ssr_pkg::ssr_cmd_e      cmd_op,
    input  wire logic [3:0]             cmd_loc,
    input  wire logic [7:0]             cmd_data,
    input  wire ssr_pkg::ssr_settings_s cmd_settings,
    output      logic                   cmd_ready,
    // command answer
    output      logic                   cmd_done,
    output      logic                   exec_error,
    output      logic                   resp_valid,
    output      logic [7:0]             resp_data,
    // straps and options
    input  wire logic                   psc_clear,
    input  wire logic                   recall_switch,
    // status summaries
    input  wire logic                   oper_summary,
    input  wire logic                   esb_summary,
    input  wire logic                   ques_summary,
    input  wire logic                   msg_avail_set,
    input  wire logic                   msg_avail_clr,
    // serial poll
    input  wire logic                   poll_req,
    output      logic                   poll_valid,
    output      logic [7:0]             poll_data,
    output      logic                   srq,
    // live state
    output      ssr_pkg::ssr_settings_s live_settings,
    output      logic                   cal_enable,
    output      logic                   abort_trig,
    output      logic                   sre_nv_write
);
    typedef enum logic [1:0] {SSR_PH_POWER_UP, SSR_PH_ABORT, SSR_PH_LOAD,
                              SSR_PH_IDLE} ssr_phase_e;
    typedef enum logic [1:0] {SSR_PEND_NONE, SSR_PEND_RECALL, SSR_PEND_RESET} ssr_pend_e;

    typedef struct packed {
        ssr_phase_e             phase;
        ssr_pend_e              pend;
        logic                   from_cmd;
        logic [3:0]             loc;
        ssr_pkg::ssr_settings_s settings;
        logic                   cal_enable;
        logic [7:0]             sre;
        logic                   mav;
        logic                   rqs;
        logic                   mss_prev;
        logic                   ready;
        logic                   done;
        logic                   err;
        logic                   resp_valid;
        logic [7:0]             resp_data;
        logic                   poll_valid;
        logic [7:0]             poll_data;
        logic                   abort;
        logic                   nv_write;
    } ssr_top_s;

    localparam ssr_top_s TOP_RESET = '{
        phase: SSR_PH_POWER_UP, pend: SSR_PEND_NONE, from_cmd: 1'b0,
        loc: ssr_pkg::POWER_ON_LOC, settings: ssr_pkg::FACTORY_SETTINGS,
        cal_enable: 1'b0, sre: ssr_pkg::SRE_RESET, mav: 1'b0, rqs: 1'b0,
        mss_prev: 1'b0, ready: 1'b0, done: 1'b0, err: 1'b0, resp_valid: 1'b0,
        resp_data: 8'h00, poll_valid: 1'b0, poll_data: 8'h00, abort: 1'b0,
        nv_write: 1'b0};

    ssr_top_s               st_reg;
    ssr_top_s               st_next;
    ssr_pkg::ssr_settings_s slot_rd;
    logic [7:0]             sre_nv_q;
    logic [7:0]             stb_value;
    logic                   mss;
    logic                   acc;
    logic                   loc_ok;
    logic                   save_wr;
    logic                   sre_nv_wr;

    ////////////////////////////////////////////////////////////////////////////////
    // storage and status byte
    assign acc       = cmd_valid && st_reg.ready;
    assign loc_ok    = cmd_loc <= ssr_pkg::LAST_LOC;
    assign save_wr   = acc && cmd_op == ssr_pkg::SSR_CMD_SAVE && loc_ok;
    assign sre_nv_wr = acc && cmd_op == ssr_pkg::SSR_CMD_SRE_WR && !psc_clear;

    ssr_slot_store u_store (
        .core_clk    (core_clk),
        .wr_en       (save_wr),
        .wr_idx      (cmd_loc),
        .wr_data     (st_reg.settings),
        .copy_base   (st_reg.phase == SSR_PH_POWER_UP),
        .rd_idx      (st_reg.loc),
        .rd_data     (slot_rd),
        .sre_nv_wr   (sre_nv_wr),
        .sre_nv_data (cmd_data),
        .sre_nv_q    (sre_nv_q)
    );

    ssr_stb_compose u_stb (
        .oper_summary (oper_summary),
        .esb_summary  (esb_summary),
        .mav          (st_reg.mav),
        .ques_summary (ques_summary),
        .sre          (st_reg.sre),
        .stb_value    (stb_value),
        .mss          (mss)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_next            = st_reg;
        st_next.done       = 1'b0;
        st_next.err        = 1'b0;
        st_next.resp_valid = 1'b0;
        st_next.poll_valid = 1'b0;
        st_next.abort      = 1'b0;
        st_next.nv_write   = 1'b0;
        st_next.mss_prev   = mss;

        // request flag rises with the master summary; a poll clears it, a rise wins
        if (poll_req) begin
            st_next.poll_valid = 1'b1;
            st_next.poll_data  = stb_value;
            st_next.poll_data[ssr_pkg::MSS_BIT] = st_reg.rqs;
            st_next.rqs        = 1'b0;
        end
        if (mss && !st_reg.mss_prev) begin
            st_next.rqs = 1'b1;
        end

        // message available, set wins over clear
        if (msg_avail_clr) begin
            st_next.mav = 1'b0;
        end
        if (acc && cmd_op == ssr_pkg::SSR_CMD_CLS) begin
            st_next.mav = 1'b0;
        end
        if (msg_avail_set) begin
            st_next.mav = 1'b1;
        end

        unique case (st_reg.phase)
            SSR_PH_POWER_UP: begin
                st_next.sre      = psc_clear ? ssr_pkg::SRE_RESET : sre_nv_q;
                st_next.pend     = recall_switch ? SSR_PEND_RECALL : SSR_PEND_NONE;
                st_next.loc      = ssr_pkg::POWER_ON_LOC;
                st_next.from_cmd = 1'b0;
                st_next.abort    = 1'b1;
                st_next.phase    = SSR_PH_ABORT;
            end
            SSR_PH_ABORT: begin
                st_next.phase = SSR_PH_LOAD;
            end
            SSR_PH_LOAD: begin
                if (st_reg.pend == SSR_PEND_RECALL) begin
                    st_next.settings   = slot_rd;
                    st_next.cal_enable = 1'b0;
                end else if (st_reg.pend == SSR_PEND_RESET) begin
                    st_next.settings   = ssr_pkg::FACTORY_SETTINGS;
                    st_next.cal_enable = 1'b0;
                end
                st_next.pend  = SSR_PEND_NONE;
                st_next.done  = st_reg.from_cmd;
                st_next.ready = 1'b1;
                st_next.phase = SSR_PH_IDLE;
            end
            SSR_PH_IDLE: begin
                if (acc) begin
                    st_next.done = 1'b1;
                    unique case (cmd_op)
                        ssr_pkg::SSR_CMD_SET: st_next.settings = cmd_settings;
                        ssr_pkg::SSR_CMD_CAL: st_next.cal_enable = cmd_data[0];
                        ssr_pkg::SSR_CMD_SAVE: st_next.err = !loc_ok;
                        ssr_pkg::SSR_CMD_RECALL: begin
                            if (loc_ok) begin
                                st_next.done     = 1'b0;
                                st_next.ready    = 1'b0;
                                st_next.loc      = cmd_loc;
                                st_next.pend     = SSR_PEND_RECALL;
                                st_next.from_cmd = 1'b1;
                                st_next.abort    = 1'b1;
                                st_next.phase    = SSR_PH_ABORT;
                            end else begin
                                st_next.err = 1'b1;
                            end
                        end
                        ssr_pkg::SSR_CMD_RESET: begin
                            st_next.done     = 1'b0;
                            st_next.ready    = 1'b0;
                            st_next.pend     = SSR_PEND_RESET;
                            st_next.from_cmd = 1'b1;
                            st_next.abort    = 1'b1;
                            st_next.phase    = SSR_PH_ABORT;
                        end
                        ssr_pkg::SSR_CMD_SRE_WR: begin
                            st_next.sre      = cmd_data;
                            st_next.nv_write = !psc_clear;
                        end
                        ssr_pkg::SSR_CMD_CLS: ;
                        ssr_pkg::SSR_CMD_STB_Q: begin
                            st_next.resp_valid = 1'b1;
                            st_next.resp_data  = stb_value;
                        end
                        ssr_pkg::SSR_CMD_SRE_Q: begin
                            st_next.resp_valid = 1'b1;
                            st_next.resp_data  = st_reg.sre;
                        end
                        default: st_next.err = 1'b1;
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg <= TOP_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs
    assign cmd_ready     = st_reg.ready;
    assign cmd_done      = st_reg.done;
    assign exec_error    = st_reg.err;
    assign resp_valid    = st_reg.resp_valid;
    assign resp_data     = st_reg.resp_data;
    assign poll_valid    = st_reg.poll_valid;
    assign poll_data     = st_reg.poll_data;
    assign srq           = st_reg.rqs;
    assign live_settings = st_reg.settings;
    assign cal_enable    = st_reg.cal_enable;
    assign abort_trig    = st_reg.abort;
    assign sre_nv_write  = st_reg.nv_write;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    AST_RECALL_ABORT_FIRST: assert property (
        acc && cmd_op == ssr_pkg::SSR_CMD_RECALL && loc_ok
        |=> abort_trig && !cmd_ready ##1 !abort_trig ##1 cmd_done && cmd_ready)
        else $error("recall did not abort before loading");
    AST_RECALL_RESTORES: assert property (
        st_reg.phase == SSR_PH_LOAD && st_reg.pend == SSR_PEND_RECALL
        |=> live_settings == $past(slot_rd))
        else $error("recall did not restore the stored settings");
    AST_RECALL_CAL_OFF: assert property (
        acc && cmd_op == ssr_pkg::SSR_CMD_RECALL && loc_ok |=> ##2 !cal_enable)
        else $error("calibration left enabled after recall");
    AST_RESET_FACTORY: assert property (
        acc && cmd_op == ssr_pkg::SSR_CMD_RESET
        |=> abort_trig ##2 live_settings == ssr_pkg::FACTORY_SETTINGS && !cal_enable)
        else $error("reset did not abort and load factory values");
    AST_SRE_ZERO_NO_SRQ: assert property (
        st_reg.sre == 8'h00 && !srq |=> !srq)
        else $error("service request raised with zero enable");
    AST_POLL_FORMAT: assert property (
        poll_req && !(mss && !st_reg.mss_prev)
        |=> poll_valid && poll_data[ssr_pkg::MSS_BIT] == $past(srq) && !srq
            && (poll_data & ssr_pkg::STB_UNUSED) == 8'h00)
        else $error("serial poll answer or flag clear wrong");
    AST_STB_QUERY: assert property (
        acc && cmd_op == ssr_pkg::SSR_CMD_STB_Q && !poll_req && !msg_avail_clr && !msg_avail_set
        |=> resp_valid && resp_data[ssr_pkg::MSS_BIT] == $past(mss)
            && (resp_data & ssr_pkg::STB_UNUSED) == 8'h00 && st_reg.mav == $past(st_reg.mav))
        else $error("status byte query wrong or disturbed status");
    AST_SRE_NV_WRITE: assert property (
        acc && cmd_op == ssr_pkg::SSR_CMD_SRE_WR |=> sre_nv_write == !$past(psc_clear))
        else $error("retained enable write does not follow option");
    AST_BAD_LOC: assert property (
        acc && (cmd_op == ssr_pkg::SSR_CMD_SAVE || cmd_op == ssr_pkg::SSR_CMD_RECALL)
        && !loc_ok |=> exec_error && cmd_ready && !abort_trig && $stable(live_settings))
        else $error("bad location not rejected cleanly");
    AST_CLS_MAV: assert property (
        acc && cmd_op == ssr_pkg::SSR_CMD_CLS && !msg_avail_set |=> !st_reg.mav)
        else $error("clear-status left message available set");

    COV_RECALL: cover property (acc && cmd_op == ssr_pkg::SSR_CMD_RECALL && loc_ok);
    COV_RESET: cover property (acc && cmd_op == ssr_pkg::SSR_CMD_RESET);
    COV_POLL_RQS: cover property (srq ##1 poll_req ##1 poll_valid);
    COV_SAVE_VOL: cover property (save_wr && cmd_loc >= ssr_pkg::FIRST_VOL_LOC);
endmodule // ssr_state_store

// [test/ssr_ctl_model.sv]
// bus controller model: serial polls the device whenever it requests service
// assumes srq and poll results come from core_clk flops of the device
`timescale 1ns/10ps
module ssr_ctl_model (
    // clock
    input  wire logic       core_clk,
    // poll link
    input  wire logic       srq,
    input  wire logic       poll_valid,
    input  wire logic [7:0] poll_data,
    output      logic       poll_req,
    output      logic [7:0] last_poll
);
    always @(negedge core_clk) begin
        poll_req <= srq && !poll_req;
        if (poll_valid) begin
            last_poll <= poll_data;
        end
    end
endmodule // ssr_ctl_model

// [test/tb_top.sv]
// self-checking bench: command sequences with expected values, partner polls
// assumes one 200 MHz clock; inputs change on the falling edge
`timescale 1ns/10ps
module tb_top;
    logic core_clk, sys_rst, cmd_valid, cmd_ready, cmd_done, exec_error, resp_valid;
    logic psc_clear, recall_switch, oper_summary, esb_summary, ques_summary;
    logic msg_avail_set, msg_avail_clr, poll_req, poll_valid, srq, cal_enable;
    logic abort_trig, sre_nv_write, got_err, got_nv, got_ab, got_rv;
    logic [3:0] cmd_loc;
    logic [7:0] cmd_data, resp_data, poll_data, last_poll, got_resp;
    ssr_pkg::ssr_cmd_e      cmd_op;
    ssr_pkg::ssr_settings_s cmd_settings, live_settings, sa, sb;
    int miscompares = 0;
    int compares    = 0;

    ssr_state_store dut (.core_clk(core_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_loc(cmd_loc), .cmd_data(cmd_data),
        .cmd_settings(cmd_settings), .cmd_ready(cmd_ready), .cmd_done(cmd_done),
        .exec_error(exec_error), .resp_valid(resp_valid), .resp_data(resp_data),
        .psc_clear(psc_clear), .recall_switch(recall_switch),
        .oper_summary(oper_summary), .esb_summary(esb_summary),
        .ques_summary(ques_summary), .msg_avail_set(msg_avail_set),
        .msg_avail_clr(msg_avail_clr), .poll_req(poll_req), .poll_valid(poll_valid),
        .poll_data(poll_data), .srq(srq), .live_settings(live_settings),
        .cal_enable(cal_enable), .abort_trig(abort_trig), .sre_nv_write(sre_nv_write));
    ssr_ctl_model u_ctl (.core_clk(core_clk), .srq(srq), .poll_valid(poll_valid),
        .poll_data(poll_data), .poll_req(poll_req), .last_poll(last_poll));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        if (miscompares == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // one command: hold request until taken, then wait for completion
    task automatic cmd(input ssr_pkg::ssr_cmd_e op, input logic [3:0] loc,
                       input logic [7:0] dat);
        int n;
        @(negedge core_clk);
        cmd_op    = op;
        cmd_loc   = loc;
        cmd_data  = dat;
        cmd_valid = 1'b1;
        for (n = 0; n < 20 && cmd_ready !== 1'b1; n++) begin
            @(negedge core_clk);
        end
        @(negedge core_clk);
        cmd_valid = 1'b0;
        got_ab    = 1'b0;
        for (n = 0; n < 8 && cmd_done !== 1'b1; n++) begin
            got_ab = got_ab | abort_trig;
            @(negedge core_clk);
        end
        got_err  = exec_error;
        got_nv   = sre_nv_write;
        got_resp = resp_data;
        got_rv   = resp_valid;
        chk(cmd_done, 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        #20000;
        miscompares++;
        stop_test;
    end
    initial begin
        {sys_rst, psc_clear} = 2'h3;
        {cmd_valid, recall_switch, oper_summary, esb_summary, ques_summary} = 5'h00;
        {msg_avail_set, msg_avail_clr, cmd_loc, cmd_data} = 14'h0000;
        cmd_op       = ssr_pkg::SSR_CMD_SET;
        cmd_settings = ssr_pkg::FACTORY_SETTINGS;
        sa           = ssr_pkg::FACTORY_SETTINGS;
        sa.voltage   = 16'h1234;
        sa.output_on = 1'b1;
        sb           = sa;
        sb.autocal   = 1'b1;
        sb.trig_delay = 16'h00A5;
        sb.relay_polarity = 1'b1;
        sb.trig_source = ssr_pkg::SSR_SRC_EXTERNAL;
        repeat (10) @(negedge core_clk);
        sys_rst = 1'b0;
        cmd(ssr_pkg::SSR_CMD_SRE_Q, 4'h0, 8'h00);
        chk(got_resp, 8'h00);
        chk(live_settings, ssr_pkg::FACTORY_SETTINGS);
        cmd_settings = sa;
        cmd(ssr_pkg::SSR_CMD_SET, 4'h0, 8'h00);
        cmd(ssr_pkg::SSR_CMD_SAVE, 4'h0, 8'h00);
        cmd_settings = sb;
        cmd(ssr_pkg::SSR_CMD_SET, 4'h0, 8'h00);
        cmd(ssr_pkg::SSR_CMD_SAVE, 4'h7, 8'h00);
        cmd(ssr_pkg::SSR_CMD_CAL, 4'h0, 8'h01);
        cmd(ssr_pkg::SSR_CMD_RESET, 4'h0, 8'h00);
        chk(got_ab, 1'b1);
        chk({cal_enable, live_settings}, {1'b0, ssr_pkg::FACTORY_SETTINGS});
        cmd(ssr_pkg::SSR_CMD_CAL, 4'h0, 8'h01);
        cmd(ssr_pkg::SSR_CMD_RECALL, 4'h7, 8'h00);
        chk(got_ab, 1'b1);
        chk(live_settings, sb);
        chk(cal_enable, 1'b0);
        cmd(ssr_pkg::SSR_CMD_RECALL, 4'hA, 8'h00);
        chk({got_err, live_settings}, {1'b1, sb});
        psc_clear = 1'b0;
        cmd(ssr_pkg::SSR_CMD_SRE_WR, 4'h0, 8'h20);
        chk(got_nv, 1'b1);
        esb_summary = 1'b1;
        repeat (6) @(negedge core_clk);
        chk({srq, last_poll}, 9'h060);
        cmd(ssr_pkg::SSR_CMD_STB_Q, 4'h0, 8'h00);
        chk({got_rv, got_resp}, 9'h160);
        psc_clear = 1'b1;
        cmd(ssr_pkg::SSR_CMD_SRE_WR, 4'h0, 8'h00);
        chk(got_nv, 1'b0);
        {oper_summary, ques_summary, msg_avail_set} = 3'h7;
        @(negedge core_clk);
        msg_avail_set = 1'b0;
        repeat (4) @(negedge core_clk);
        chk(srq, 1'b0);
        cmd(ssr_pkg::SSR_CMD_STB_Q, 4'h0, 8'h00);
        chk(got_resp, 8'hB8);
        cmd(ssr_pkg::SSR_CMD_CLS, 4'h0, 8'h00);
        cmd(ssr_pkg::SSR_CMD_STB_Q, 4'h0, 8'h00);
        chk(got_resp, 8'hA8);
        {msg_avail_set, msg_avail_clr} = 2'h3;
        @(negedge core_clk);
        {msg_avail_set, msg_avail_clr} = 2'h0;
        cmd(ssr_pkg::SSR_CMD_STB_Q, 4'h0, 8'h00);
        chk(got_resp, 8'hB8);
        msg_avail_clr = 1'b1;
        @(negedge core_clk);
        msg_avail_clr = 1'b0;
        cmd(ssr_pkg::SSR_CMD_STB_Q, 4'h0, 8'h00);
        chk(got_resp, 8'hA8);
        psc_clear = 1'b0;
        cmd(ssr_pkg::SSR_CMD_SRE_WR, 4'h0, 8'h28);
        {recall_switch, msg_avail_set, sys_rst} = 3'h7;
        repeat (3) @(negedge core_clk);
        {msg_avail_set, sys_rst} = 2'h0;
        cmd(ssr_pkg::SSR_CMD_SRE_Q, 4'h0, 8'h00);
        chk(got_resp, 8'h28);
        chk(live_settings, sa);
        cmd(ssr_pkg::SSR_CMD_STB_Q, 4'h0, 8'h00);
        chk(got_resp, 8'hE8);
        cmd(ssr_pkg::SSR_CMD_RECALL, 4'h5, 8'h00);
        chk(live_settings, sa);
        stop_test;
    end
endmodule // tb_top
